//--- design/nvs_byte_store.sv
`timescale 1ns/1ps
`include "nvs_cfg.svh"

module nvs_byte_store #(
	parameter int OSC_KHZ = `NVS_OSC_KHZ,
	parameter int TICK_W = 16,
	parameter int ATOMIC_TICKS = `NVS_T_ATOMIC_US * OSC_KHZ / 1000,
	parameter int SPLIT_TICKS = `NVS_T_SPLIT_US * OSC_KHZ / 1000
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst_n,
	input wire logic por_n,
	// Calibrated oscillator tick, asynchronous
	input wire logic osc_tick,
	// Pointer register write
	input wire logic ptr_wr,
	input wire logic [`NVS_ADDR_W-1:0] ptr_wdata,
	// Value register write
	input wire logic val_wr,
	input wire logic [`NVS_DATA_W-1:0] val_wdata,
	// Control register writes
	input wire logic mode_wr,
	input wire nvs_pkg::nvs_mode_t mode_wdata,
	input wire logic arm_set,
	input wire logic trigger_set,
	input wire logic read_strobe,
	// Register contents
	output logic [`NVS_ADDR_W-1:0] nv_byte_pointer,
	output logic [`NVS_DATA_W-1:0] nv_byte_value,
	output nvs_pkg::nvs_mode_t program_mode_sel,
	output logic master_write_arm,
	output logic program_trigger,
	// Processor hold
	output logic cpu_stall
);
	import nvs_pkg::*;

	// Terminal tick count for a mode
	function automatic logic [TICK_W-1:0] mode_ticks(input nvs_mode_t m);
		if (m == NVS_MODE_ATOMIC) begin
			mode_ticks = TICK_W'(ATOMIC_TICKS);
		end else begin
			mode_ticks = TICK_W'(SPLIT_TICKS);
		end
	endfunction

	// Synchronisers for oscillator tick and reset level
	logic tick_q1_r, tick_q2_r, tick_q3_r;
	logic rst_q1_r, rst_q2_r;
	logic tick_pulse;

	// Only q2 and later feed logic
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			tick_q1_r <= 1'b0;
			tick_q2_r <= 1'b0;
			tick_q3_r <= 1'b0;
		end else begin
			tick_q1_r <= osc_tick;
			tick_q2_r <= tick_q1_r;
			tick_q3_r <= tick_q2_r;
		end
	end

	// System reset seen as a level by the power-on domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q1_r <= 1'b0;
			rst_q2_r <= 1'b0;
		end else begin
			rst_q1_r <= 1'b1;
			rst_q2_r <= rst_q1_r;
		end
	end

	assign tick_pulse = tick_q2_r & ~tick_q3_r;

	// Engine state lives on power-on reset so it survives system reset
	nvs_state_t state_r, state_nxt;
	logic [TICK_W-1:0] tick_cnt_r, tick_cnt_nxt;
	logic [TICK_W-1:0] tick_end_r, tick_end_nxt;
	nvs_mode_t op_mode_r, op_mode_nxt;
	logic [`NVS_ADDR_W-1:0] op_addr_r, op_addr_nxt;
	logic [`NVS_DATA_W-1:0] op_data_r, op_data_nxt;
	logic trig_r, trig_nxt;
	nvs_mode_t mode_r, mode_nxt;

	// Software-side registers, cleared by system reset
	logic [`NVS_ADDR_W-1:0] ptr_r, ptr_nxt;
	logic [`NVS_DATA_W-1:0] val_r, val_nxt;
	logic [2:0] arm_cnt_r, arm_cnt_nxt;
	logic arm_r, arm_nxt;
	logic [2:0] stall_cnt_r, stall_cnt_nxt;
	logic stall_r, stall_nxt;
	logic rd_pend_r, rd_pend_nxt;

	// Store port
	logic mem_re, mem_we;
	logic [`NVS_ADDR_W-1:0] mem_addr;
	logic [`NVS_DATA_W-1:0] mem_wdata;
	logic [`NVS_DATA_W-1:0] mem_rdata;

	logic busy;
	logic start;
	logic rd_go;

	assign busy = (state_r != NVS_ST_IDLE);

	assign start = trigger_set & arm_r & ~busy & rst_q2_r & (mode_r != NVS_MODE_RSVD);

	assign rd_go = read_strobe & ~busy & ~start & rst_q2_r;

	// Programming engine next state
	always_comb begin
		state_nxt = state_r;
		tick_cnt_nxt = tick_cnt_r;
		tick_end_nxt = tick_end_r;
		op_mode_nxt = op_mode_r;
		op_addr_nxt = op_addr_r;
		op_data_nxt = op_data_r;
		trig_nxt = trig_r;
		unique case (state_r)
			NVS_ST_IDLE: begin
				if (start) begin
					op_addr_nxt = ptr_r;
					op_data_nxt = val_r;
					op_mode_nxt = mode_r;
					tick_end_nxt = mode_ticks(mode_r);
					tick_cnt_nxt = '0;
					trig_nxt = 1'b1;
					state_nxt = NVS_ST_RUN;
				end
			end
			NVS_ST_RUN: begin
				if (tick_pulse) begin
					tick_cnt_nxt = tick_cnt_r + TICK_W'(1);
				end
				if (tick_cnt_r >= tick_end_r) begin
					state_nxt = NVS_ST_COMMIT;
				end
			end
			NVS_ST_COMMIT: begin
				trig_nxt = 1'b0;
				state_nxt = NVS_ST_IDLE;
			end
			default: begin
				trig_nxt = 1'b0;
				state_nxt = NVS_ST_IDLE;
			end
		endcase
	end

	// engine runs on power-on reset only
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			state_r <= NVS_ST_IDLE;
			tick_cnt_r <= '0;
			tick_end_r <= '0;
			op_mode_r <= NVS_MODE_ATOMIC;
			op_addr_r <= `NVS_PTR_RST;
			op_data_r <= `NVS_VAL_RST;
			trig_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			tick_cnt_r <= tick_cnt_nxt;
			tick_end_r <= tick_end_nxt;
			op_mode_r <= op_mode_nxt;
			op_addr_r <= op_addr_nxt;
			op_data_r <= op_data_nxt;
			trig_r <= trig_nxt;
		end
	end

	// Mode field next value
	always_comb begin
		mode_nxt = mode_r;
		if (!rst_q2_r) begin
			if (!busy) begin
				mode_nxt = nvs_mode_t'(`NVS_MODE_RST);
			end
		end else if (mode_wr && !trig_r) begin
			mode_nxt = mode_wdata;
		end
	end

	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			mode_r <= nvs_mode_t'(`NVS_MODE_RST);
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Store access: commit write or a single read
	always_comb begin
		mem_re = 1'b0;
		mem_we = 1'b0;
		mem_addr = ptr_r;
		mem_wdata = op_data_r;
		if (state_r == NVS_ST_COMMIT) begin
			mem_we = 1'b1;
			mem_addr = op_addr_r;
			unique case (op_mode_r)
				NVS_MODE_ATOMIC: mem_wdata = op_data_r;
				NVS_MODE_ERASE: mem_wdata = `NVS_ERASED;
				default: mem_wdata = mem_rdata & op_data_r;
			endcase
		end else if (start) begin
			// Old content fetched for write-only merge
			mem_re = 1'b1;
		end else if (rd_go) begin
			mem_re = 1'b1;
		end
	end

	nvs_store #(
		.AW(`NVS_ADDR_W),
		.DW(`NVS_DATA_W)
	) u_store (
		.clk(clk),
		.por_n(por_n),
		.re(mem_re),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata_r(mem_rdata)
	);

	// Software registers next value
	always_comb begin
		ptr_nxt = ptr_r;
		val_nxt = val_r;
		arm_cnt_nxt = arm_cnt_r;
		arm_nxt = arm_r;
		stall_cnt_nxt = stall_cnt_r;
		rd_pend_nxt = rd_go;
		if (ptr_wr && !busy) begin
			ptr_nxt = ptr_wdata;
		end
		// Value kept stable while it is being programmed
		if (val_wr && !busy) begin
			val_nxt = val_wdata;
		end
		if (rd_pend_r) begin
			val_nxt = mem_rdata;
		end
		if (arm_set) begin
			arm_nxt = 1'b1;
			arm_cnt_nxt = `NVS_ARM_WINDOW;
		end else if (arm_cnt_r != 3'h0) begin
			arm_cnt_nxt = arm_cnt_r - 3'h1;
			arm_nxt = (arm_cnt_r != 3'h1);
		end else begin
			arm_nxt = 1'b0;
		end
		if (rd_go) begin
			stall_cnt_nxt = `NVS_READ_STALL;
		end else if (start) begin
			stall_cnt_nxt = `NVS_PROG_STALL;
		end else if (stall_cnt_r != 3'h0) begin
			stall_cnt_nxt = stall_cnt_r - 3'h1;
		end
		stall_nxt = (stall_cnt_nxt != 3'h0);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_r <= `NVS_PTR_RST;
			val_r <= `NVS_VAL_RST;
			arm_cnt_r <= 3'h0;
			arm_r <= 1'b0;
			stall_cnt_r <= 3'h0;
			stall_r <= 1'b0;
			rd_pend_r <= 1'b0;
		end else begin
			ptr_r <= ptr_nxt;
			val_r <= val_nxt;
			arm_cnt_r <= arm_cnt_nxt;
			arm_r <= arm_nxt;
			stall_cnt_r <= stall_cnt_nxt;
			stall_r <= stall_nxt;
			rd_pend_r <= rd_pend_nxt;
		end
	end

	// Outputs straight from flops
	assign nv_byte_pointer = ptr_r;
	assign nv_byte_value = val_r;
	assign program_mode_sel = mode_r;
	assign master_write_arm = arm_r;
	assign program_trigger = trig_r;
	assign cpu_stall = stall_r;

endmodule

//--- design/nvs_cfg.svh
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// Store geometry
`define NVS_ADDR_W 9
`define NVS_DATA_W 8

// Reset values and erased byte value
`define NVS_PTR_RST 9'h000
`define NVS_VAL_RST 8'h00
`define NVS_MODE_RST 2'h0
`define NVS_ERASED 8'hFF

// Processor stall lengths, in clock cycles
`define NVS_READ_STALL 3'h4
`define NVS_PROG_STALL 3'h2

// Arming window, in clock cycles
`define NVS_ARM_WINDOW 3'h4

// Programming times, in microseconds
`define NVS_T_ATOMIC_US 3400
`define NVS_T_SPLIT_US 1800

// Default calibrated oscillator tick rate, in kHz
`define NVS_OSC_KHZ 1000

`endif

//--- design/nvs_pkg.sv
package nvs_pkg;

	// Programming mode field encodings
	typedef enum logic [1:0] {
		NVS_MODE_ATOMIC = 2'h0,
		NVS_MODE_ERASE = 2'h1,
		NVS_MODE_WRITE = 2'h2,
		NVS_MODE_RSVD = 2'h3
	} nvs_mode_t;

	// Programming engine states, one-hot
	typedef enum logic [2:0] {
		NVS_ST_IDLE = 3'b001,
		NVS_ST_RUN = 3'b010,
		NVS_ST_COMMIT = 3'b100
	} nvs_state_t;

endpackage

//--- design/nvs_store.sv
`timescale 1ns/1ps
`include "nvs_cfg.svh"

module nvs_store #(
	parameter int AW = `NVS_ADDR_W,
	parameter int DW = `NVS_DATA_W
) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic por_n,
	// Access port
	input wire logic re,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_r
);

	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_nxt;

	// Read data is held until the next read
	always_comb begin
		rdata_nxt = rdata_r;
		if (re) begin
			rdata_nxt = mem[addr];
		end
	end

	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Array has no reset, like real cells
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

endmodule

//--- test/nvs_byte_store_properties.sv
`timescale 1ns/1ps
module nvs_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests
	input wire logic arm_set,
	input wire logic trigger_set,
	input wire logic read_strobe,
	// Register contents
	input wire logic [8:0] nv_byte_pointer,
	input wire logic [7:0] nv_byte_value,
	input wire nvs_pkg::nvs_mode_t program_mode_sel,
	input wire logic master_write_arm,
	input wire logic program_trigger,
	input wire logic cpu_stall
);
	import nvs_pkg::*;

	// One clock domain, so one default clock and disable
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_arm_holds_four: assert property (arm_set |=> master_write_arm [*4])
		else $error("arm window short");
	a_arm_self_clears: assert property (arm_set ##1 !arm_set [*4] |=> !master_write_arm)
		else $error("arm did not clear");
	a_start_needs_arm: assert property ($rose(program_trigger) |-> $past(trigger_set && master_write_arm))
		else $error("start without arm");
	a_no_arm_no_start: assert property (trigger_set && !master_write_arm && !program_trigger |=> !program_trigger)
		else $error("unarmed start");
	a_rsvd_no_start: assert property (trigger_set && master_write_arm && program_mode_sel == NVS_MODE_RSVD
		&& !program_trigger |=> !program_trigger)
		else $error("reserved mode started");
	a_prog_stall_two: assert property ($rose(program_trigger) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall)
		else $error("program stall length");
	a_read_stall_four: assert property (read_strobe && !program_trigger && !(trigger_set && master_write_arm)
		|=> cpu_stall [*4] ##1 !cpu_stall)
		else $error("read stall length");
	a_busy_regs_hold: assert property (program_trigger |=> $stable(nv_byte_pointer) && $stable(nv_byte_value)
		&& $stable(program_mode_sel))
		else $error("register changed while busy");
	a_busy_bounded: assert property ($rose(program_trigger) |-> program_trigger [*8] ##[1:600] !program_trigger)
		else $error("busy length");
endmodule

bind nvs_byte_store nvs_chk nvs_chk_inst (.clk, .rst_n, .arm_set, .trigger_set, .read_strobe, .nv_byte_pointer,
	.nv_byte_value, .program_mode_sel, .master_write_arm, .program_trigger, .cpu_stall);

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
	import nvs_pkg::*;
	logic clk, rst_n, por_n, osc_tick, ptr_wr, val_wr, mode_wr, arm_set, trigger_set, read_strobe;
	logic [8:0] ptr_wdata, nv_byte_pointer;
	logic [7:0] val_wdata, nv_byte_value;
	nvs_mode_t mode_wdata, program_mode_sel;
	logic master_write_arm, program_trigger, cpu_stall;
	int fails = 0;
	int total_checks = 0;
	// Cycles the last busy poll waited, for per-mode duration checks
	int busy_n = 0;

	// Short tick counts keep each program cycle under a hundred clocks
	nvs_byte_store #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) nvs_byte_store_inst (.clk, .rst_n, .por_n, .osc_tick,
		.ptr_wr, .ptr_wdata, .val_wr, .val_wdata, .mode_wr, .mode_wdata, .arm_set, .trigger_set, .read_strobe,
		.nv_byte_pointer, .nv_byte_value, .program_mode_sel, .master_write_arm, .program_trigger, .cpu_stall);

	// System clock
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	// Tick source, period unrelated to clk
	initial begin
		osc_tick = 0;
		forever #170 osc_tick = ~osc_tick;
	end

	// Compare tasks
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t flag %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t value %h want %h", $time, got, exp);
		end
	endtask

	// Pointer, value and mode written together
	task automatic setup(input logic [8:0] a, input logic [7:0] v, input nvs_mode_t m);
		@(negedge clk);
		{ptr_wr, val_wr, mode_wr} = 3'h7;
		ptr_wdata = a;
		val_wdata = v;
		mode_wdata = m;
		@(negedge clk);
		{ptr_wr, val_wr, mode_wr} = 3'h0;
	endtask
	// Arm, then trigger d cycles later
	task automatic prog(input int d);
		@(negedge clk);
		arm_set = 1;
		@(negedge clk);
		arm_set = 0;
		chk_bit(master_write_arm, 1'b1);
		repeat (d - 1) @(negedge clk);
		trigger_set = 1;
		@(negedge clk);
		trigger_set = 0;
	endtask
	// Bounded poll of the busy flag
	task automatic wait_idle;
		int n;
		n = 0;
		while (program_trigger !== 1'b0 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		busy_n = n;
		chk_bit(program_trigger, 1'b0);
	endtask
	// Value lands two cycles after the strobe; stall outlasts it
	task automatic rd(input logic [8:0] a, input logic [7:0] exp);
		@(negedge clk);
		ptr_wr = 1;
		ptr_wdata = a;
		@(negedge clk);
		ptr_wr = 0;
		read_strobe = 1;
		@(negedge clk);
		read_strobe = 0;
		repeat (2) @(negedge clk);
		chk_val({1'b0, nv_byte_value}, {1'b0, exp});
		chk_bit(cpu_stall, 1'b1);
		repeat (3) @(negedge clk);
	endtask
	// Requests wait three edges after release for the reset sync
	task automatic rst_pulse;
		@(negedge clk);
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(40 * 20000);
		fails++;
		wrap_up;
	end

	initial begin
		{ptr_wr, val_wr, mode_wr, arm_set, trigger_set, read_strobe} = 6'h00;
		ptr_wdata = 9'h000;
		val_wdata = 8'h00;
		mode_wdata = NVS_MODE_ATOMIC;
		rst_n = 0;
		por_n = 0;
		repeat (4) @(negedge clk);
		rst_n = 1;
		por_n = 1;
		repeat (3) @(negedge clk);
		chk_val({7'h00, program_mode_sel}, 9'h000);
		chk_bit(program_trigger, 1'b0);
		$display("test reset done");
		// Atomic program; writes and read refused while busy
		setup(9'h1A5, 8'h3C, NVS_MODE_ATOMIC);
		prog(1);
		chk_bit(program_trigger, 1'b1);
		chk_bit(cpu_stall, 1'b1);
		setup(9'h0F0, 8'h11, NVS_MODE_ERASE);
		@(negedge clk);
		read_strobe = 1;
		@(negedge clk);
		read_strobe = 0;
		@(negedge clk);
		chk_bit(cpu_stall, 1'b0);
		chk_val(nv_byte_pointer, 9'h1A5);
		chk_val({1'b0, nv_byte_value}, 9'h03C);
		chk_val({7'h00, program_mode_sel}, 9'h000);
		wait_idle;
		// Atomic runs eight ticks, far past any split run even with the poll starting late
		chk_bit(busy_n > 48, 1'b1);
		rd(9'h1A5, 8'h3C);
		$display("test atomic done");
		// Erase top byte at the window edge, then write only
		setup(9'h1FF, 8'h55, NVS_MODE_ERASE);
		prog(4);
		chk_bit(program_trigger, 1'b1);
		wait_idle;
		// Split runs four ticks, well short of the atomic time
		chk_bit(busy_n < 44, 1'b1);
		rd(9'h1FF, 8'hFF);
		// Write-only lands on the byte just erased
		setup(9'h1FF, 8'h5A, NVS_MODE_WRITE);
		prog(2);
		wait_idle;
		rd(9'h1FF, 8'h5A);
		$display("test split done");
		// Late trigger and reserved mode start nothing
		setup(9'h000, 8'h77, NVS_MODE_ATOMIC);
		prog(5);
		chk_bit(program_trigger, 1'b0);
		chk_bit(master_write_arm, 1'b0);
		setup(9'h000, 8'h77, NVS_MODE_RSVD);
		prog(1);
		chk_bit(program_trigger, 1'b0);
		$display("test refused done");
		// Reset in mid-erase: operation and mode survive
		setup(9'h010, 8'h00, NVS_MODE_ERASE);
		prog(3);
		rst_pulse;
		chk_bit(program_trigger, 1'b1);
		chk_val({7'h00, program_mode_sel}, 9'h001);
		wait_idle;
		rd(9'h010, 8'hFF);
		rst_pulse;
		chk_val({7'h00, program_mode_sel}, 9'h000);
		$display("test reset busy done");
		wrap_up;
	end
endmodule
